//--- design/blx_defs.svh
// offsets, field positions, reset values and clock counts of the decoder
// assumes inclusion by the execution module
`ifndef BLX_DEFS_SVH
`define BLX_DEFS_SVH
`define BLX_OFS_CTRL 8'h00
`define BLX_OFS_STATUS 8'h04
`define BLX_OFS_CX 8'h08
`define BLX_OFS_IP 8'h0C
`define BLX_OFS_AX 8'h10
`define BLX_OFS_SI 8'h14
`define BLX_OFS_DI 8'h18
`define BLX_CTRL_MAX 0
`define BLX_CTRL_ZF 1
`define BLX_CTRL_DF 2
`define BLX_STAT_BUSY 0
`define BLX_STAT_LOCK 1
`define BLX_STAT_UNDEF 2
`define BLX_MAX_RST 1'b0
`define BLX_OP_LOCK 8'hF0
`define BLX_CLK_LOOP_T 5'd17
`define BLX_CLK_LOOP_N 5'd5
`define BLX_CLK_LOOP_IF_ZERO_SET_ALIAS_T 5'd18
`define BLX_CLK_LOOP_IF_ZERO_SET_ALIAS_N 5'd6
`define BLX_CLK_LOOP_IF_ZERO_CLEAR_ALIAS_T 5'd19
`define BLX_CLK_LOOP_IF_ZERO_CLEAR_ALIAS_N 5'd5
`define BLX_SEG_ES 2'h0
`define BLX_SEG_DS 2'h3
`endif

//--- design/blx_pkg.sv
// types shared by the decoder: sequencer states and the state record
// assumes blx_defs.svh sits beside it
package blx_pkg;
    typedef enum logic [3:0] {
        S_FETCH, S_LOCKW, S_MODRM, S_OPND, S_EXEC, S_RD, S_WB, S_WR, S_WAIT
    } blx_state_t;
    typedef enum logic [0:0] { S_UNUSED } blx_dummy_t;
    typedef struct packed {
        blx_state_t st;
        logic [7:0] op;
        logic [7:0] modrm;
        logic [2:0] need;
        logic [2:0] nb;
        logic [1:0] dl;
        logic [31:0] opnd;
        logic w;
        logic rep;
        logic lk_pend;
        logic lk_act;
        logic ovr_v;
        logic [1:0] ovr;
        logic [7:0][15:0] gpr;
        logic [3:0][15:0] seg;
        logic [15:0] ip;
        logic [15:0] addr;
        logic [15:0] data;
        logic bi;
        logic zf;
        logic df;
        logic max_mode;
        logic undef;
        logic [4:0] cyc;
        logic [4:0] tgt;
        logic mreq;
        logic mwe;
        logic [1:0] mseg;
        logic flush;
        logic wp;
        logic [7:0] waddr;
        logic [31:0] hrdata;
    } blx_st_t;
endpackage

//--- design/blx_exec.sv
// decode and execute of bus lock, string load/copy, counted loops, moves
// assumes a byte fetch queue, an 8-bit memory port and an AHB-Lite master
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`include "blx_defs.svh"
module blx_exec import blx_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic ib_valid,
    input wire logic [7:0] ib_data,
    output logic ib_ready,
    output logic [15:0] fetch_ip,
    output logic fetch_flush,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_seg,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic lock_n
);
    logic [1:0] rsync;
    logic rst_n;
    blx_st_t s;
    blx_st_t n;
    logic take;

    function automatic logic [15:0] rreg(logic [7:0][15:0] g, logic w,
                                         logic [2:0] r);
        if (w)
            return g[r];
        return {8'h00, r[2] ? g[{1'b0, r[1:0]}][15:8] : g[r][7:0]};
    endfunction

    function automatic logic [7:0][15:0] wreg(logic [7:0][15:0] g,
                                              logic w, logic [2:0] r,
                                              logic [15:0] v);
        if (w)
            g[r] = v;
        else if (r[2])
            g[{1'b0, r[1:0]}][15:8] = v[7:0];
        else
            g[r][7:0] = v[7:0];
        return g;
    endfunction

    // index step by element size; direction flag picks down
    function automatic logic [15:0] step(logic [15:0] x, logic w, logic d);
        logic [15:0] dl;
        dl = w ? 16'h0002 : 16'h0001;
        return d ? x - dl : x + dl;
    endfunction

    function automatic logic [15:0] ea(logic [7:0][15:0] g, logic [7:0] m,
                                       logic [31:0] o, logic [1:0] dl);
        logic [15:0] b;
        logic [15:0] d;
        case (m[2:0])
            3'h0: b = g[3] + g[6];
            3'h1: b = g[3] + g[7];
            3'h2: b = g[5] + g[6];
            3'h3: b = g[5] + g[7];
            3'h4: b = g[6];
            3'h5: b = g[7];
            3'h6: b = (m[7:6] == 2'b00) ? 16'h0000 : g[5];
            default: b = g[3];
        endcase
        d = (dl == 2'd1) ? {{8{o[7]}}, o[7:0]} :
            (dl == 2'd2) ? o[15:0] : 16'h0000;
        return b + d;
    endfunction

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rsync <= 2'b00;
        else
            rsync <= {rsync[0], 1'b1};
    end
    assign rst_n = rsync[1];

    assign ib_ready = rst_n && (s.st == S_FETCH || s.st == S_MODRM ||
                                s.st == S_OPND);
    assign take = ib_valid && ib_ready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign fetch_ip = s.ip;
    assign fetch_flush = s.flush;
    assign mem_req = s.mreq;
    assign mem_we = s.mwe;
    assign mem_addr = s.addr;
    assign mem_seg = s.mseg;
    assign mem_wdata = s.data[7:0];
    assign lock_n = !(s.lk_act && s.max_mode);

    always_comb
    begin
        logic [15:0] v;
        logic [15:0] c;
        logic [1:0] dseg;
        logic fin;
        logic tk;
        v = 16'h0000;
        c = 16'h0000;
        fin = 1'b0;
        tk = 1'b0;
        n = s;
        n.flush = 1'b0;
        dseg = s.ovr_v ? s.ovr : `BLX_SEG_DS;
        if (s.st != S_FETCH && s.cyc != 5'h1F)
            n.cyc = s.cyc + 5'd1;
        // register file over AHB: read data staged in the address phase
        n.wp = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            n.wp = hwrite;
            n.waddr = haddr[7:0];
            case (haddr[7:0])
                `BLX_OFS_CTRL: n.hrdata = {29'h0, s.df, s.zf, s.max_mode};
                `BLX_OFS_STATUS: n.hrdata = {29'h0, s.undef,
                    s.lk_act & s.max_mode, s.st != S_FETCH};
                `BLX_OFS_CX: n.hrdata = {16'h0, s.gpr[1]};
                `BLX_OFS_IP: n.hrdata = {16'h0, s.ip};
                `BLX_OFS_AX: n.hrdata = {16'h0, s.gpr[0]};
                `BLX_OFS_SI: n.hrdata = {16'h0, s.gpr[6]};
                `BLX_OFS_DI: n.hrdata = {16'h0, s.gpr[7]};
                default: n.hrdata = 32'h0000_0000;
            endcase
        end
        // flags change only by software, never by the sequencer
        if (s.wp && s.waddr == `BLX_OFS_CTRL)
        begin
            n.max_mode = hwdata[`BLX_CTRL_MAX];
            n.zf = hwdata[`BLX_CTRL_ZF];
            n.df = hwdata[`BLX_CTRL_DF];
        end
        case (s.st)
            S_FETCH:
                if (take)
                begin
                    n.ip = s.ip + 16'h0001;
                    n.op = ib_data;
                    n.cyc = 5'd1;
                    n.nb = 3'd0;
                    n.dl = 2'd0;
                    n.w = ib_data[0];
                    n.undef = 1'b0;
                    casez (ib_data)
                        `BLX_OP_LOCK:
                        begin
                            n.lk_pend = 1'b1;
                            n.st = S_LOCKW;
                        end
                        8'hF2, 8'hF3: n.rep = 1'b1;
                        8'b001??110:
                        begin
                            n.ovr_v = 1'b1;
                            n.ovr = ib_data[4:3];
                        end
                        8'b100010??, 8'b1100011?: n.st = S_MODRM;
                        8'h8C, 8'h8E:
                        begin
                            n.w = 1'b1;
                            n.st = S_MODRM;
                        end
                        8'b1011????:
                        begin
                            n.w = ib_data[3];
                            n.need = ib_data[3] ? 3'd2 : 3'd1;
                            n.st = S_OPND;
                        end
                        8'b1010001?:
                        begin
                            n.need = 3'd2;
                            n.st = S_OPND;
                        end
                        8'hE0, 8'hE1, 8'hE2:
                        begin
                            n.need = 3'd1;
                            n.st = S_OPND;
                        end
                        8'b1010110?, 8'b1010010?: n.st = S_EXEC;
                        default: n.undef = 1'b1;
                    endcase
                    if (n.st != S_FETCH && n.st != S_LOCKW && s.lk_pend)
                    begin
                        n.lk_act = 1'b1;
                        n.lk_pend = 1'b0;
                    end
                    if (n.undef)
                        fin = 1'b1;
                end
            S_LOCKW: n.st = S_FETCH;
            S_MODRM:
                if (take)
                begin
                    n.ip = s.ip + 16'h0001;
                    n.modrm = ib_data;
                    if (ib_data[7:6] == 2'b01)
                        n.dl = 2'd1;
                    else if (ib_data[7:6] == 2'b10 ||
                             (ib_data[7:6] == 2'b00 && ib_data[2:0] == 3'h6))
                        n.dl = 2'd2;
                    n.need = {1'b0, n.dl};
                    if (s.op[7:1] == 7'b1100011)
                        n.need = {1'b0, n.dl} + (s.w ? 3'd2 : 3'd1);
                    n.st = (n.need == 3'd0) ? S_EXEC : S_OPND;
                end
            S_OPND:
                if (take)
                begin
                    n.ip = s.ip + 16'h0001;
                    n.opnd[{s.nb[1:0], 3'b000} +: 8] = ib_data;
                    n.nb = s.nb + 3'd1;
                    if (n.nb == s.need)
                        n.st = S_EXEC;
                end
            S_EXEC:
            begin
                n.addr = ea(s.gpr, s.modrm, s.opnd, s.dl);
                n.mseg = dseg;
                n.bi = 1'b0;
                casez (s.op)
                    8'b100010??:
                        if (s.modrm[7:6] == 2'b11)
                        begin
                            if (s.op[1])
                                n.gpr = wreg(s.gpr, s.w, s.modrm[5:3],
                                    rreg(s.gpr, s.w, s.modrm[2:0]));
                            else
                                n.gpr = wreg(s.gpr, s.w, s.modrm[2:0],
                                    rreg(s.gpr, s.w, s.modrm[5:3]));
                            fin = 1'b1;
                        end
                        else
                        begin
                            n.data = rreg(s.gpr, s.w, s.modrm[5:3]);
                            n.st = s.op[1] ? S_RD : S_WR;
                        end
                    8'b1100011?:
                    begin
                        n.data = s.opnd[{s.dl, 3'b000} +: 16];
                        if (s.modrm[7:6] == 2'b11)
                        begin
                            n.gpr = wreg(s.gpr, s.w, s.modrm[2:0], n.data);
                            fin = 1'b1;
                        end
                        else
                            n.st = S_WR;
                    end
                    8'b1011????:
                    begin
                        n.gpr = wreg(s.gpr, s.w, s.op[2:0], s.opnd[15:0]);
                        fin = 1'b1;
                    end
                    8'b1010001?:
                    begin
                        n.addr = s.opnd[15:0];
                        n.data = s.gpr[0];
                        n.st = S_WR;
                    end
                    8'h8E:
                        if (s.modrm[4:3] == 2'b01)
                        begin
                            n.undef = 1'b1;
                            fin = 1'b1;
                        end
                        else if (s.modrm[7:6] == 2'b11)
                        begin
                            n.seg[s.modrm[4:3]] = s.gpr[s.modrm[2:0]];
                            fin = 1'b1;
                        end
                        else
                            n.st = S_RD;
                    8'h8C:
                    begin
                        n.data = s.seg[s.modrm[4:3]];
                        if (s.modrm[7:6] == 2'b11)
                        begin
                            n.gpr[s.modrm[2:0]] = n.data;
                            fin = 1'b1;
                        end
                        else
                            n.st = S_WR;
                    end
                    8'b1010110?, 8'b1010010?:
                        if (s.rep && s.gpr[1] == 16'h0000)
                            fin = 1'b1;
                        else
                        begin
                            n.addr = s.gpr[6];
                            n.st = S_RD;
                        end
                    default:
                    begin
                        // counted loops; every other opcode ends before here
                        c = s.gpr[1] - 16'h0001;
                        n.gpr[1] = c;
                        tk = c != 16'h0000 && (s.op[1] || s.op[0] == s.zf);
                        if (tk)
                        begin
                            n.ip = s.ip + {{8{s.opnd[7]}}, s.opnd[7:0]};
                            n.flush = 1'b1;
                        end
                        case (s.op[1:0])
                            2'b10: n.tgt = tk ? `BLX_CLK_LOOP_T
                                              : `BLX_CLK_LOOP_N;
                            2'b01: n.tgt = tk ? `BLX_CLK_LOOP_IF_ZERO_SET_ALIAS_T
                                              : `BLX_CLK_LOOP_IF_ZERO_SET_ALIAS_N;
                            default: n.tgt = tk ? `BLX_CLK_LOOP_IF_ZERO_CLEAR_ALIAS_T
                                                : `BLX_CLK_LOOP_IF_ZERO_CLEAR_ALIAS_N;
                        endcase
                        n.st = S_WAIT;
                    end
                endcase
                n.mreq = (n.st == S_RD || n.st == S_WR);
                n.mwe = (n.st == S_WR);
            end
            S_RD:
                if (mem_ack)
                begin
                    n.data = {mem_rdata, s.data[15:8]};
                    n.addr = s.addr + 16'h0001;
                    n.bi = 1'b1;
                    if (s.bi == s.w)
                    begin
                        n.mreq = 1'b0;
                        n.st = S_WB;
                    end
                end
            S_WB:
            begin
                v = s.w ? s.data : {8'h00, s.data[15:8]};
                n.bi = 1'b0;
                casez (s.op)
                    8'h8E: n.seg[s.modrm[4:3]] = s.data;
                    8'b1010110?:
                    begin
                        n.gpr = wreg(s.gpr, s.w, 3'h0, v);
                        n.gpr[6] = step(s.gpr[6], s.w, s.df);
                        if (s.rep)
                            n.gpr[1] = s.gpr[1] - 16'h0001;
                    end
                    8'b1010010?:
                    begin
                        n.data = v;
                        n.addr = s.gpr[7];
                        n.mseg = `BLX_SEG_ES;
                        n.mreq = 1'b1;
                        n.mwe = 1'b1;
                    end
                    default: n.gpr = wreg(s.gpr, s.w, s.modrm[5:3], v);
                endcase
                if (s.op[7:1] == 7'b1010010)
                    n.st = S_WR;
                else if (s.op[7:1] == 7'b1010110 && s.rep)
                    n.st = S_EXEC;
                else
                    fin = 1'b1;
            end
            S_WR:
                if (mem_ack)
                begin
                    n.data = {8'h00, s.data[15:8]};
                    n.addr = s.addr + 16'h0001;
                    n.bi = 1'b1;
                    if (s.bi == s.w)
                    begin
                        n.mreq = 1'b0;
                        n.mwe = 1'b0;
                        if (s.op[7:1] == 7'b1010010)
                        begin
                            n.gpr[6] = step(s.gpr[6], s.w, s.df);
                            n.gpr[7] = step(s.gpr[7], s.w, s.df);
                            if (s.rep)
                            begin
                                n.gpr[1] = s.gpr[1] - 16'h0001;
                                n.st = S_EXEC;
                            end
                            else
                                fin = 1'b1;
                        end
                        else
                            fin = 1'b1;
                    end
                end
            S_WAIT:
                if (s.cyc >= s.tgt - 5'd1)
                    fin = 1'b1;
            default: n.st = S_FETCH;
        endcase
        // repeat, override and active lock prefixes apply to one instruction only
        if (fin)
        begin
            n.st = S_FETCH;
            n.rep = 1'b0;
            n.ovr_v = 1'b0;
            n.lk_act = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= n;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence lock_wait_s;
        s.st == S_LOCKW ##1 s.st == S_FETCH;
    endsequence
    // extra condition folded in: a sequence cannot be an operand of &&
    sequence loop_start_s(logic [7:0] o, logic c);
        s.st == S_EXEC && s.op == o && s.cyc == 5'd2 && c;
    endsequence

    a_lock_two_clk: assert property (
        (s.st == S_FETCH && take && ib_data == `BLX_OP_LOCK) |=> lock_wait_s)
        else $error("lock prefix not two clocks");
    a_lock_held: assert property (
        (s.lk_act && s.max_mode && s.st != S_FETCH) |-> !lock_n)
        else $error("lock output dropped during locked instruction");
    a_lock_idle: assert property (
        (s.st == S_FETCH && !s.lk_act) |-> lock_n)
        else $error("lock output active outside locked instruction");
    a_pfx_combine: assert property (
        (s.st == S_FETCH && take && ib_data == `BLX_OP_LOCK && s.rep)
            |=> s.rep ##1 s.rep)
        else $error("repeat prefix lost across lock prefix");
    a_flags_kept: assert property (
        !(s.wp && s.waddr == `BLX_OFS_CTRL) |=> $stable(s.zf) && $stable(s.df))
        else $error("flag changed without software write");
    a_loop_taken: assert property (
        loop_start_s(8'hE2, s.gpr[1] != 16'h0001) |-> ##15 s.st == S_FETCH)
        else $error("loop taken time wrong");
    a_loop_fall: assert property (
        loop_start_s(8'hE2, s.gpr[1] == 16'h0001) |-> ##3 s.st == S_FETCH)
        else $error("loop not-taken time wrong");
    a_loop_if_zero_set_alias_time: assert property (
        loop_start_s(8'hE1, s.gpr[1] != 16'h0001 && s.zf)
            |-> ##16 s.st == S_FETCH)
        else $error("zero loop taken time wrong");
    a_loop_if_zero_clear_alias_time: assert property (
        loop_start_s(8'hE0, s.gpr[1] != 16'h0001 && !s.zf)
            |-> ##17 s.st == S_FETCH)
        else $error("not-zero loop taken time wrong");
    a_load_string_op_step: assert property (
        (s.st == S_WB && s.op[7:1] == 7'b1010110 && !s.df)
            |=> s.gpr[6] == $past(s.gpr[6]) + (s.w ? 16'h0002 : 16'h0001))
        else $error("load string index step wrong");
    a_string_copy_op_order: assert property (
        (s.st == S_WB && s.op[7:1] == 7'b1010010)
            |=> s.st == S_WR && mem_we && mem_seg == `BLX_SEG_ES)
        else $error("string copy write phase missing");
    a_seg_undef: assert property (
        (s.st == S_EXEC && s.op == 8'h8E && s.modrm[4:3] == 2'b01)
            |=> s.undef && s.st == S_FETCH)
        else $error("segment code 01 not flagged");
endmodule

//--- verification/blx_mem.sv
// byte memory on the far side of the execution block's data port
// assumes one request at a time, held by the block until acknowledged
module blx_mem (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // only the low address byte decodes: the program stays inside 256 bytes
    logic [7:0] mem [0:255];
    logic [3:0] lfsr;
    logic [1:0] dly;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h5A;
    end
    // data toggles outside the ack cycle so stale bytes never look valid
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_ack <= 1'b0;
            lfsr <= 4'h9;
            dly <= 2'h1;
            mem_rdata <= 8'h00;
        end
        else if (!mem_ack && mem_req && dly == 2'h0)
        begin
            mem_ack <= 1'b1;
            if (mem_we)
                mem[mem_addr[7:0]] <= mem_wdata;
            mem_rdata <= mem[mem_addr[7:0]];
            lfsr <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
            dly <= lfsr[1:0];
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack)
                dly <= dly - 2'h1;
        end
    end
endmodule

//--- verification/test_bus_lock_string_loop_move_exec.sv
// bench: a program through the byte queue, results read back over AHB-Lite
// assumes the byte memory model on the data port
module test_bus_lock_string_loop_move_exec;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0, go = 0, note = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r32, x = 32'h2AC82933;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, ib_ready, fetch_flush, mem_req, mem_we, mem_ack;
    logic lock_n, ib_valid, hready;
    logic [15:0] fetch_ip, mem_addr, rv;
    logic [7:0] mem_wdata, mem_rdata, ib_data, ptr = 0, n;
    logic [7:0] prog [0:51];
    logic [31:0] expq [$];
    int n_errors = 0, checks_done = 0, nlk = 0;
    assign hready = hreadyout;
    assign ib_valid = go && ptr < 8'd52;
    assign ib_data = prog[ptr < 8'd52 ? ptr : 8'd0];
    blx_exec blx_exec_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ib_valid(ib_valid),
        .ib_data(ib_data), .ib_ready(ib_ready), .fetch_ip(fetch_ip),
        .fetch_flush(fetch_flush), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_seg(), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .lock_n(lock_n));
    blx_mem blx_mem_inst (.clk(clk), .reset_n(reset_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    initial
        forever #12.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic chk, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        note <= chk;
        @(posedge clk);
        while (hready !== 1'b1)
            @(posedge clk);
        r = hrdata;
        note <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        ahb(1'b0, a, 32'h0, 1'b1, r32);
    endtask
    task automatic summarize;
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // results are compared in the cycle the read data stands
    always @(posedge clk)
    begin
        if (note && hready)
            check(hrdata, expq.pop_front());
        if (fetch_flush)
            ptr <= fetch_ip[7:0];
        else if (ib_valid && ib_ready)
            ptr <= ptr + 8'd1;
        if (mem_ack && !lock_n)
            nlk <= nlk + 1;
    end
    initial
    begin
        #1000000;
        n_errors++;
        summarize();
    end
    initial
    begin
        x = xs(x);
        rv = x[15:0];
        x = xs(x);
        n = {6'h0, x[1:0]} + 8'd1;
        prog = '{8'hB8, rv[7:0], rv[15:8], 8'hB9, n, 8'h00, 8'hE2, 8'hFE,
            8'hB9, 8'h03, 8'h00, 8'hE0, 8'hFE, 8'hE1, 8'hFE, 8'hA3, 8'h20,
            8'h00, 8'hBE, 8'h20, 8'h00, 8'hBF, 8'h40, 8'h00, 8'hF0, 8'hA5,
            8'hAC, 8'h8E, 8'hDE, 8'h8C, 8'h1E, 8'h50, 8'h00, 8'h8E, 8'hC8,
            8'h88, 8'h06, 8'h52, 8'h00, 8'h8A, 8'h26, 8'h50, 8'h00, 8'hC6,
            8'h06, 8'h54, 8'h00, 8'hC3, 8'hF3, 8'hF0, 8'h26, 8'hA4};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        ahb(1'b1, 8'h00, 32'h3, 1'b0, r32);
        go <= 1'b1;
        for (int i = 0; i < 3000 && ptr != 8'd52; i++)
            @(posedge clk);
        r32 = 32'h1;
        for (int i = 0; i < 100 && r32[0] !== 1'b0; i++)
            ahb(1'b0, 8'h04, 32'h0, 1'b0, r32);
        rd(8'h00, 32'h3);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h0C, 32'h34);
        rd(8'h10, 32'h2378);
        rd(8'h14, 32'h23);
        rd(8'h18, 32'h42);
        rd(8'h1C, 32'h0);
        check({16'h0, blx_mem_inst.mem[8'h41], blx_mem_inst.mem[8'h40]},
            {16'h0, rv});
        check({16'h0, blx_mem_inst.mem[8'h51], blx_mem_inst.mem[8'h50]},
            32'h23);
        check({24'h0, blx_mem_inst.mem[8'h52]}, 32'h78);
        check({24'h0, blx_mem_inst.mem[8'h54]}, 32'hC3);
        check(32'(nlk), 32'h4);
        summarize();
    end
endmodule
